//--- rtl/nvac_pkg.sv
// Constants, register map and timing for the data storage access controller.
// Assumes an APB slave with 32-bit data and byte-addressed word registers.
package nvac_pkg;
  // Register indices; the bus byte address is four times the index
  localparam logic [11:0] IDX_DATA = 12'h008;
  localparam logic [11:0] IDX_PTR = 12'h009;
  localparam logic [11:0] IDX_CTRL = 12'h088;
  localparam logic [11:0] IDX_UNLK = 12'h089;
  localparam logic [11:0] OFS_DATA = IDX_DATA << 2;
  localparam logic [11:0] OFS_PTR = IDX_PTR << 2;
  localparam logic [11:0] OFS_CTRL = IDX_CTRL << 2;
  localparam logic [11:0] OFS_UNLK = IDX_UNLK << 2;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h100;
  localparam logic [11:0] OFS_IRQ_EN = 12'h104;
  localparam logic [11:0] OFS_IRQ_CLR = 12'h108;
  localparam int DEPTH = 64;
  localparam int ADDR_W = 6;
  localparam int BIT_RD = 0;
  localparam int BIT_WR = 1;
  localparam int BIT_PERMIT = 2;
  localparam int BIT_ABORT = 3;
  localparam int BIT_DONE = 4;
  localparam logic [7:0] UNLOCK_1 = 8'h55;
  localparam logic [7:0] UNLOCK_2 = 8'haa;
  localparam logic [7:0] CELL_RESET = 8'hff;
  localparam int CLK_MHZ = 200;
  localparam int WRITE_US = 4;
  localparam int WRITE_CYC = WRITE_US * CLK_MHZ;
  localparam int PWRUP_MS = 72;
  localparam int PWRUP_CYC = PWRUP_MS * 1000 * CLK_MHZ;
  localparam int ERASE_CYC = WRITE_CYC / 2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ERASE = 3'b010,
    ST_PROG = 3'b100
  } nvac_state_t;
  typedef enum logic [2:0] {
    UL_NONE = 3'b001,
    UL_FIRST = 3'b010,
    UL_ARMED = 3'b100
  } nvac_unlock_t;
endpackage : nvac_pkg

//--- rtl/nvac_array.sv
// Flip-flop model of the 64-byte storage array with erase and program ports.
// Assumes one controller drives the strobes, at most one per cycle.
`timescale 1ns/1ps
module nvac_array
  import nvac_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic erase_i,
  input wire logic prog_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] cell_reg [DEPTH];
  assign rdata_o = cell_reg[addr_i];
  // ----------------------------------------------------------------------
  // Cells
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (erase_i)
    begin
      cell_reg[addr_i] <= CELL_RESET;
    end
    else if (prog_i)
    begin
      cell_reg[addr_i] <= wdata_i;
    end
  end
endmodule : nvac_array

//--- rtl/nvac_top.sv
// Access controller: APB registers, unlock sequence, self-timed writes.
// Assumes asynchronous reset and watchdog events; programmer on this clock.
`timescale 1ns/1ps
module nvac_top
  import nvac_pkg::*;
#(
  parameter int PWRUP_CYCLES = PWRUP_CYC,
  parameter int WRITE_CYCLES = WRITE_CYC
)
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic power_on_i,
  input wire logic external_reset_pin_i,
  input wire logic watchdog_timeout_i,
  input wire logic code_protect_i,
  input wire logic prog_req_i,
  input wire logic [ADDR_W-1:0] prog_addr_i,
  output logic [7:0] prog_rdata_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o
);
  import nvac_pkg::*;
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  nvac_state_t state_reg;
  nvac_state_t state_next;
  nvac_unlock_t unl_reg;
  nvac_unlock_t unl_next;
  logic [7:0] data_reg;
  logic [7:0] data_next;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic [7:0] wlatch_reg;
  logic [ADDR_W-1:0] alatch_reg;
  logic permit_reg;
  logic permit_next;
  logic abort_reg;
  logic abort_next;
  logic done_reg;
  logic done_next;
  logic rd_reg;
  logic [31:0] tmr_reg;
  logic [31:0] tmr_next;
  logic [31:0] pwr_reg;
  logic [1:0] irq_en_reg;
  logic [1:0] irq_en_next;
  logic [7:0] prog_rdata_reg;
  logic [31:0] prdata_reg;
  logic [1:0] ext_sync_reg;
  logic [1:0] wdog_sync_reg;
  logic [1:0] irq_stat;
  logic [1:0] irq_pend;
  // ----------------------------------------------------------------------
  // Reset event synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    ext_sync_reg <= {ext_sync_reg[0], external_reset_pin_i};
    wdog_sync_reg <= {wdog_sync_reg[0], watchdog_timeout_i};
  end
  wire reset_hit = ext_sync_reg[1] || wdog_sync_reg[1];
  wire por_hit = !rst_b_i && power_on_i;
  wire warm_hit = !rst_b_i && !power_on_i;
  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire acc = psel_i && penable_i;
  wire wr_acc = acc && pwrite_i && pstrb_i[0];
  wire rd_acc = acc && !pwrite_i;
  wire hit_data = paddr_i == OFS_DATA;
  wire hit_ptr = paddr_i == OFS_PTR;
  wire hit_ctrl = paddr_i == OFS_CTRL;
  wire hit_unlk = paddr_i == OFS_UNLK;
  wire hit_stat = paddr_i == OFS_IRQ_STAT;
  wire hit_en = paddr_i == OFS_IRQ_EN;
  wire hit_clr = paddr_i == OFS_IRQ_CLR;
  wire mapped = hit_data | hit_ptr | hit_ctrl | hit_unlk | hit_stat | hit_en
              | hit_clr;
  wire [7:0] wb = pwdata_i[7:0];
  wire busy = state_reg != ST_IDLE;
  wire pwr_running = pwr_reg != 32'h0;
  wire wr_ctrl = wr_acc && hit_ctrl;
  wire wr_unlk = wr_acc && hit_unlk;
  wire set_rd = wr_ctrl && wb[BIT_RD];
  wire set_wr = wr_ctrl && wb[BIT_WR];
  wire start_wr = set_wr && permit_reg && (unl_reg == UL_ARMED) && !busy
                && !pwr_running;
  wire tmr_end = tmr_reg == 32'h0;
  wire fin_erase = (state_reg == ST_ERASE) && tmr_end;
  wire fin_prog = (state_reg == ST_PROG) && tmr_end;
  wire [31:0] erase_len = 32'((WRITE_CYCLES / 2 < 1) ? 1 : WRITE_CYCLES / 2);
  wire abort_set = busy && reset_hit;
  wire abort_clr = (wr_ctrl && !wb[BIT_ABORT])
                 || (wr_acc && hit_clr && wb[0]);
  wire done_clr = (wr_ctrl && !wb[BIT_DONE])
                || (wr_acc && hit_clr && wb[1]);
  // ----------------------------------------------------------------------
  // Array port
  // ----------------------------------------------------------------------
  logic [7:0] arr_rdata;
  wire [ADDR_W-1:0] arr_addr = busy ? alatch_reg
                             : (prog_req_i ? prog_addr_i
                             : ptr_reg[ADDR_W-1:0]);
  wire ptr_in_range = ptr_reg[7:ADDR_W] == 2'b00;
  wire prog_ok = prog_req_i && !code_protect_i && !busy;
  nvac_array nvac_array_i (
    .core_clk_i(core_clk_i),
    .addr_i(arr_addr),
    .erase_i(fin_erase),
    .prog_i(fin_prog),
    .wdata_i(wlatch_reg),
    .rdata_o(arr_rdata)
  );
  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    tmr_next = tmr_reg;
    unique case (state_reg)
      ST_IDLE:
      begin
        if (start_wr)
        begin
          state_next = ST_ERASE;
          tmr_next = erase_len;
        end
      end
      ST_ERASE:
      begin
        if (tmr_end)
        begin
          state_next = ST_PROG;
          tmr_next = 32'(WRITE_CYCLES - WRITE_CYCLES / 2);
        end
        else
        begin
          tmr_next = tmr_reg - 32'h1;
        end
      end
      ST_PROG:
      begin
        if (tmr_end)
        begin
          state_next = ST_IDLE;
        end
        else
        begin
          tmr_next = tmr_reg - 32'h1;
        end
      end
    endcase
  end
  always_comb
  begin
    unl_next = unl_reg;
    if (wr_unlk)
    begin
      if (wb == UNLOCK_1)
      begin
        unl_next = UL_FIRST;
      end
      else if (wb == UNLOCK_2 && unl_reg == UL_FIRST)
      begin
        unl_next = UL_ARMED;
      end
      else
      begin
        unl_next = UL_NONE;
      end
    end
    else if (wr_acc)
    begin
      unl_next = UL_NONE;
    end
  end
  assign permit_next = wr_ctrl ? wb[BIT_PERMIT] : permit_reg;
  assign abort_next = abort_set || (abort_reg && !abort_clr);
  assign done_next = fin_prog || (done_reg && !done_clr);
  assign data_next = rd_reg ? (ptr_in_range ? arr_rdata : 8'h00)
                   : ((wr_acc && hit_data) ? wb : data_reg);
  assign ptr_next = (wr_acc && hit_ptr) ? wb : ptr_reg;
  assign irq_en_next = (wr_acc && hit_en) ? wb[1:0] : irq_en_reg;
  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  wire [7:0] ctrl_view = {3'b000, done_reg, abort_reg, permit_reg, busy,
                          rd_reg};
  wire [7:0] rmux = hit_data ? data_reg
                  : hit_ptr ? ptr_reg
                  : hit_ctrl ? ctrl_view
                  : hit_stat ? {6'h00, done_reg, abort_reg}
                  : hit_en ? {6'h00, irq_en_reg}
                  : 8'h00;
  // ----------------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      state_reg <= ST_IDLE;
      tmr_reg <= 32'h0;
      unl_reg <= UL_NONE;
      rd_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      unl_reg <= start_wr ? UL_NONE : unl_next;
      rd_reg <= set_rd && !rd_reg;
    end
  end
  // ----------------------------------------------------------------------
  // Software registers, kept over a warm reset
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (por_hit)
    begin
      permit_reg <= 1'b0;
      data_reg <= 8'h00;
      ptr_reg <= 8'h00;
    end
    else if (rst_b_i)
    begin
      permit_reg <= permit_next;
      data_reg <= data_next;
      ptr_reg <= ptr_next;
    end
  end
  // holding, pointer and permit kept through warm reset
  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (por_hit)
    begin
      abort_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else if (warm_hit)
    begin
      abort_reg <= abort_reg | busy;
    end
    else
    begin
      abort_reg <= abort_next;
      done_reg <= done_next;
    end
  end
  // ----------------------------------------------------------------------
  // Power-up write block timer
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (por_hit)
    begin
      pwr_reg <= 32'(PWRUP_CYCLES);
    end
    else if (rst_b_i && pwr_running)
    begin
      pwr_reg <= pwr_reg - 32'h1;
    end
  end
  // ----------------------------------------------------------------------
  // Bus side registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      irq_en_reg <= 2'b00;
      prdata_reg <= 32'h0;
      prog_rdata_reg <= 8'h00;
    end
    else
    begin
      irq_en_reg <= irq_en_next;
      prdata_reg <= rd_acc ? {24'h0, rmux} : prdata_reg;
      prog_rdata_reg <= prog_ok ? arr_rdata : 8'h00;
    end
  end
  // ----------------------------------------------------------------------
  // Write latch
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (start_wr)
    begin
      wlatch_reg <= data_reg;
      alatch_reg <= ptr_reg[ADDR_W-1:0];
    end
  end
  assign prdata_o = rd_acc ? {24'h0, rmux} : prdata_reg;
  assign pready_o = 1'b1;
  assign pslverr_o = acc && !mapped;
  assign prog_rdata_o = prog_rdata_reg;
  // ----------------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------------
  assign irq_stat = {done_reg, abort_reg};
  for (genvar gi = 0; gi < 2; gi++)
  begin : g_irq
    assign irq_pend[gi] = irq_stat[gi] && irq_en_reg[gi];
  end
  assign irq_o = |irq_pend;
endmodule : nvac_top

//--- dv/nvac_asserts.sv
// Port checker for nvac_top register side.
// Assumes one clock and a bind onto nvac_top.
`timescale 1ns/1ps
module nvac_asserts
  import nvac_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic code_protect_i,
  input wire logic prog_req_i,
  input wire logic [7:0] prog_rdata_o,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  wire logic acc = psel_i & penable_i;
  wire logic rd = acc & !pwrite_i;
  wire logic mapd = paddr_i inside {OFS_DATA, OFS_PTR, OFS_CTRL,
    OFS_UNLK, OFS_IRQ_STAT, OFS_IRQ_EN, OFS_IRQ_CLR};
  AST_READY: assert property (acc |-> pready_o)
    else $error("no ready");
  AST_MAP_OK: assert property (acc && mapd |-> !pslverr_o)
    else $error("error on mapped");
  AST_UNMAP: assert property (acc && !mapd |-> pslverr_o)
    else $error("no error on unmapped");
  AST_CTRL_HI: assert property (
    rd && paddr_i == OFS_CTRL |-> prdata_o[31:5] == 27'h0)
    else $error("ctrl high bits");
  AST_UNLK: assert property (
    rd && paddr_i == OFS_UNLK |-> prdata_o == 32'h0)
    else $error("unlock port not zero");
  AST_DATA_W: assert property (
    rd && paddr_i == OFS_DATA |-> prdata_o[31:8] == 24'h0)
    else $error("data width");
  AST_PTR_W: assert property (
    rd && paddr_i == OFS_PTR |-> prdata_o[31:8] == 24'h0)
    else $error("pointer width");
  AST_PROT: assert property (
    prog_req_i && code_protect_i |=> prog_rdata_o == 8'h0)
    else $error("programmer read leaked");
  C_CTRL: cover property (rd && paddr_i == OFS_CTRL);
  C_PROG: cover property (prog_req_i && !code_protect_i);
  C_ERR: cover property (acc && !mapd);
endmodule : nvac_asserts

bind nvac_top nvac_asserts nvac_asserts_i (
  .core_clk_i(core_clk_i),
  .rst_b_i(rst_b_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .code_protect_i(code_protect_i),
  .prog_req_i(prog_req_i),
  .prog_rdata_o(prog_rdata_o),
  .prdata_o(prdata_o),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o)
);

//--- dv/nvac_top_tb.sv
// Self-checking bench for nvac_top over APB.
// Assumes short power-up and write counts set here.
`timescale 1ns/1ps
module nvac_top_tb;
  import nvac_pkg::*;
  localparam int PU = 40;
  localparam int WC = 20;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic power_on_i = 1'b1;
  logic external_reset_pin_i = 1'b0;
  logic watchdog_timeout_i = 1'b0;
  logic code_protect_i = 1'b0;
  logic prog_req_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [ADDR_W-1:0] prog_addr_i = '0;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0;
  logic [3:0] pstrb_i = 4'hf;
  logic [7:0] prog_rdata_o;
  logic [31:0] prdata_o, rv;
  logic pready_o, pslverr_o, irq_o, er;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  // ----
  // Clock, design, helpers
  // ----
  always #2.5 core_clk_i = ~core_clk_i;
  nvac_top #(.PWRUP_CYCLES(PU), .WRITE_CYCLES(WC)) nvac_top_i (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .power_on_i(power_on_i),
    .external_reset_pin_i(external_reset_pin_i),
    .watchdog_timeout_i(watchdog_timeout_i),
    .code_protect_i(code_protect_i),
    .prog_req_i(prog_req_i),
    .prog_addr_i(prog_addr_i),
    .prog_rdata_o(prog_rdata_o),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .irq_o(irq_o)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    rv = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rv, e);
  endtask : rdc
  task automatic unlock_start;
    wr(OFS_UNLK, 32'h55);
    wr(OFS_UNLK, 32'haa);
    wr(OFS_CTRL, 32'h6);
  endtask : unlock_start
  task automatic wait_idle;
    apb(1'b0, OFS_CTRL, 32'h0);
    repeat (40) if (rv[BIT_WR] === 1'b1) apb(1'b0, OFS_CTRL, 32'h0);
  endtask : wait_idle
  // ----
  // Scenarios
  // ----
  task automatic t_pwrup;
    rdc(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h4);
    unlock_start();
    rdc(OFS_CTRL, 32'h4);
    rdc(OFS_UNLK, 32'h0);
    repeat (PU) @(posedge core_clk_i);
  endtask : t_pwrup
  task automatic t_refuse;
    wr(OFS_CTRL, 32'h0);
    unlock_start();
    rdc(OFS_CTRL, 32'h4);
    wr(OFS_UNLK, 32'haa);
    wr(OFS_UNLK, 32'h55);
    wr(OFS_CTRL, 32'h6);
    rdc(OFS_CTRL, 32'h4);
    wr(OFS_UNLK, 32'h55);
    wr(OFS_PTR, 32'h0);
    wr(OFS_UNLK, 32'haa);
    wr(OFS_CTRL, 32'h6);
    rdc(OFS_CTRL, 32'h4);
    apb(1'b1, 12'h200, 32'h1);
    chk(32'(er), 32'h1);
  endtask : t_refuse
  task automatic t_write;
    wr(OFS_IRQ_EN, 32'h2);
    wr(OFS_PTR, 32'h3f);
    wr(OFS_DATA, 32'h3c);
    unlock_start();
    wr(OFS_CTRL, 32'h0);
    rdc(OFS_CTRL, 32'h2);
    wr(OFS_DATA, 32'h77);
    wait_idle();
    chk(rv, 32'h10);
    @(negedge core_clk_i);
    chk(32'(irq_o), 32'h1);
    wr(OFS_IRQ_EN, 32'h0);
    @(negedge core_clk_i);
    chk(32'(irq_o), 32'h0);
    wr(OFS_IRQ_CLR, 32'h2);
    rdc(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h1);
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_DATA, 32'h3c);
    wr(OFS_PTR, 32'h0);
    rdc(OFS_DATA, 32'h3c);
    wr(OFS_PTR, 32'h7f);
    rdc(OFS_PTR, 32'h7f);
    wr(OFS_CTRL, 32'h1);
    rdc(OFS_DATA, 32'h0);
  endtask : t_write
  task automatic t_prog;
    for (int p = 0; p < 2; p++)
    begin
      @(posedge core_clk_i);
      code_protect_i <= p[0];
      prog_req_i <= 1'b1;
      prog_addr_i <= 6'h3f;
      @(posedge core_clk_i);
      prog_req_i <= 1'b0;
      @(negedge core_clk_i);
      chk(32'(prog_rdata_o), p ? 32'h0 : 32'h3c);
    end
    wr(OFS_PTR, 32'h3f);
    wr(OFS_CTRL, 32'h1);
    rdc(OFS_DATA, 32'h3c);
  endtask : t_prog
  task automatic t_abort(input logic ext, input logic [31:0] d);
    wr(OFS_CTRL, 32'h4);
    wr(OFS_PTR, 32'h11);
    wr(OFS_DATA, d);
    unlock_start();
    @(posedge core_clk_i);
    rst_b_i <= 1'b0;
    external_reset_pin_i <= ext;
    watchdog_timeout_i <= !ext;
    @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    external_reset_pin_i <= 1'b0;
    watchdog_timeout_i <= 1'b0;
    rdc(OFS_CTRL, 32'hc);
    rdc(OFS_PTR, 32'h11);
    rdc(OFS_DATA, d);
    rdc(OFS_IRQ_STAT, 32'h1);
    wr(OFS_IRQ_CLR, 32'h3);
    rdc(OFS_IRQ_STAT, 32'h0);
    wr(OFS_CTRL, 32'h0);
  endtask : t_abort
  task automatic end_sim;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  always @(posedge core_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_errors++;
      end_sim();
    end
  end
  initial
  begin
    repeat (4) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    power_on_i <= 1'b0;
    t_pwrup();
    t_refuse();
    t_write();
    t_prog();
    t_abort(1'b1, 32'h5a);
    t_abort(1'b0, 32'ha5);
    end_sim();
  end
endmodule : nvac_top_tb
